// ### core/wcc_regs.vh
`ifndef WCC_REGS_VH
`define WCC_REGS_VH

// register indices, byte address is four times the index
`define WCC_IDX_CONTROL      3'h0
`define WCC_IDX_PAIR        3'h1
`define WCC_IDX_INSEL       3'h2
`define WCC_IDX_REFLEVEL    3'h5
`define WCC_IDX_IRQCTL      3'h6
`define WCC_IDX_STATUS      3'h7
`define WCC_ADR_IDX         4:2

// reset values and writable bit masks
`define WCC_RST_CONTROL     8'h00
`define WCC_RST_PAIR        8'h00
`define WCC_RST_INSEL       8'h00
`define WCC_RST_REFLEVEL    8'hff
`define WCC_RST_IRQCTL      8'h00
`define WCC_MSK_CONTROL     8'hdf
`define WCC_MSK_PAIR        8'h03
`define WCC_MSK_IRQCTL      8'h31

// field positions
`define WCC_CTL_ENABLE      0
`define WCC_CTL_HYS         2:1
`define WCC_CTL_POWER       4:3
`define WCC_CTL_PIN_OUTPUT_ENABLE       6
`define WCC_CTL_RUNSTBY     7
`define WCC_PAIR_SEL        1:0
`define WCC_INS_NEG         2:0
`define WCC_INS_POS         5:3
`define WCC_INS_STARTLVL    6
`define WCC_INS_INVERT      7
`define WCC_IRQ_EN          0
`define WCC_IRQ_MODE        5:4
`define WCC_STA_FLAG        0
`define WCC_STA_STATE       4
`define WCC_STA_WINPOS      7:6

// encodings
`define WCC_PAIR_OFF        2'h0
`define WCC_PAIR_NEXT1      2'h1
`define WCC_PAIR_NEXT2      2'h2
`define WCC_POS_ABOVE       2'h0
`define WCC_POS_INSIDE      2'h1
`define WCC_POS_BELOW       2'h2
`define WCC_MODE_OUTSIDE    2'h3
`define WCC_EDGE_BOTH       2'h0
`define WCC_EDGE_FALL       2'h2
`define WCC_EDGE_RISE       2'h3

// timing: comparator settle time after enable, clock period
`define WCC_STARTUP_NS      1000
`define WCC_CLK_NS          10
`define WCC_CNT_W           8

`endif

// ### core/wcc_core.v
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "wcc_regs.vh"

module wcc_core (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire [4:0]  adr_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // analog core results, asynchronous to clk_i
  input  wire        cmp_raw_i,
  input  wire        pair_next1_raw_i,
  input  wire        pair_next2_raw_i,
  // sleep state from the power controller
  input  wire        sleep_idle_i,
  input  wire        sleep_standby_i,
  input  wire        sleep_powerdown_i,
  // analog core settings
  output wire        analog_enable_o,
  output wire [1:0]  hysteresis_select_o,
  output wire [1:0]  power_profile_o,
  output wire [2:0]  positive_input_select_o,
  output wire [2:0]  negative_input_select_o,
  output wire [7:0]  reference_level_o,
  // pin, event and interrupt
  output wire        pin_out_o,
  output wire        pin_oe_n_o,
  output wire        event_o,
  output wire        irq_o
);

  // startup length rounded up to whole clock cycles
  localparam integer STARTUP_CYC =
    (`WCC_STARTUP_NS + `WCC_CLK_NS - 1) / `WCC_CLK_NS;
  localparam integer STARTUP_END = STARTUP_CYC - 1;
  localparam [`WCC_CNT_W-1:0] STARTUP_LAST = STARTUP_END[`WCC_CNT_W-1:0];
  localparam [`WCC_CNT_W-1:0] CNT_ZERO     = {`WCC_CNT_W{1'b0}};

  // run states
  localparam [1:0] ST_OFF   = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  // window position from the two comparator results
  function [1:0] wcc_position;
    input upper;
    input lower;
    begin
      if (upper) begin
        wcc_position = `WCC_POS_ABOVE;
      end else if (lower) begin
        wcc_position = `WCC_POS_INSIDE;
      end else begin
        wcc_position = `WCC_POS_BELOW;
      end
    end
  endfunction

  // does a position match the selected trigger condition
  function wcc_match;
    input [1:0] pos;
    input [1:0] mode;
    begin
      if (mode == `WCC_MODE_OUTSIDE) begin
        wcc_match = (pos != `WCC_POS_INSIDE);
      end else begin
        wcc_match = (pos == mode);
      end
    end
  endfunction

  reg  [7:0] control;
  reg  [7:0] pair_control;
  reg  [7:0] input_select_control;
  reg  [7:0] reference_level;
  reg  [7:0] interrupt_control;
  reg        comparator_irq_flag;

  reg  [1:0] run_state;
  reg  [1:0] next_run_state;
  reg  [`WCC_CNT_W-1:0] startup_cnt;
  reg        held_level;

  reg  [2:0] sync_self;
  reg  [2:0] sync_pair;
  reg        filt_self;
  reg        filt_pair;
  reg        prev_level;

  wire       enable_bit  = control[`WCC_CTL_ENABLE];
  wire       run_standby = control[`WCC_CTL_RUNSTBY];
  wire       invert_bit  = input_select_control[`WCC_INS_INVERT];
  wire       start_level = input_select_control[`WCC_INS_STARTLVL];
  wire [1:0] pair_sel    = pair_control[`WCC_PAIR_SEL];
  wire [1:0] trig_mode   = interrupt_control[`WCC_IRQ_MODE];
  wire       irq_enable  = interrupt_control[`WCC_IRQ_EN];

  // idle sleep does not enter here at all, so it behaves as active
  wire active = enable_bit & ~sleep_powerdown_i
              & ~(sleep_standby_i & ~run_standby);

  // reserved pair code 3 is treated as window off
  wire window_on = (pair_sel == `WCC_PAIR_NEXT1) |
                   (pair_sel == `WCC_PAIR_NEXT2);
  wire pair_raw  = (pair_sel == `WCC_PAIR_NEXT2) ?
                   pair_next2_raw_i : pair_next1_raw_i;

  // configuration to the analog core; enable gated by sleep, the rest straight from the registers
  assign analog_enable_o         = active;
  assign hysteresis_select_o     = control[`WCC_CTL_HYS];
  assign power_profile_o         = control[`WCC_CTL_POWER];
  assign positive_input_select_o = input_select_control[`WCC_INS_POS];
  assign negative_input_select_o = input_select_control[`WCC_INS_NEG];
  assign reference_level_o       = reference_level;

  // clockless output path: keeps working in standby with clock stopped
  wire [1:0] async_pos   = wcc_position(cmp_raw_i, pair_raw);
  wire       async_level = (window_on ? wcc_match(async_pos, trig_mode)
                                      : cmp_raw_i) ^ invert_bit;
  wire       out_level   = (run_state == ST_RUN) ? async_level
                                                 : held_level;

  assign event_o    = out_level;
  assign pin_out_o  = out_level;
  assign pin_oe_n_o = ~(control[`WCC_CTL_PIN_OUTPUT_ENABLE] & ~sleep_powerdown_i);

  // startup sequencing after enable
  always @* begin
    next_run_state = run_state;
    case (run_state)
      ST_OFF: begin
        if (active) begin
          next_run_state = ST_START;
        end
      end
      ST_START: begin
        if (!active) begin
          next_run_state = ST_OFF;
        end else if (startup_cnt == STARTUP_LAST) begin
          next_run_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!active) begin
          next_run_state = ST_OFF;
        end
      end
      default: begin
        next_run_state = ST_OFF;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      run_state   <= ST_OFF;
      startup_cnt <= CNT_ZERO;
    end else begin
      run_state <= next_run_state;
      if (run_state == ST_START) begin
        startup_cnt <= startup_cnt + 1'b1;
      end else begin
        startup_cnt <= CNT_ZERO;
      end
    end
  end

  // filtered view of the comparator pair, used by all clocked logic
  wire [1:0] filt_pos   = wcc_position(filt_self, filt_pair);
  wire       filt_match = wcc_match(filt_pos, trig_mode);
  wire       filt_level = (window_on ? filt_match : filt_self) ^ invert_bit;

  // held level: startup value while settling, last filtered level once stopped
  always @(posedge clk_i) begin
    if (rst_i) begin
      held_level <= 1'b0;
    end else if (run_state == ST_OFF && active) begin
      held_level <= start_level;
    end else if (run_state == ST_START) begin
      held_level <= start_level;
    end else if (run_state == ST_RUN) begin
      held_level <= filt_level;
    end
  end

  // three flop synchroniser for this comparator; a change counts only
  // once the second and third flops agree, so a metastable first flop
  // never reaches the trigger logic
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_self <= 3'h0;
      filt_self <= 1'b0;
    end else begin
      sync_self <= {sync_self[1:0], cmp_raw_i};
      if (sync_self[1] == sync_self[2]) begin
        filt_self <= sync_self[2];
      end
    end
  end

  // same for the partner result; the select mux sits ahead of it, so a
  // change of pair select settles through the flops like an input change
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_pair <= 3'h0;
      filt_pair <= 1'b0;
    end else begin
      sync_pair <= {sync_pair[1:0], pair_raw};
      if (sync_pair[1] == sync_pair[2]) begin
        filt_pair <= sync_pair[2];
      end
    end
  end

  // state bit seen by software holds while not running
  reg        state_bit;
  reg  [1:0] window_position;
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_bit       <= 1'b0;
      window_position <= `WCC_POS_ABOVE;
      prev_level      <= 1'b0;
    end else if (run_state == ST_RUN) begin
      state_bit       <= filt_level;
      window_position <= filt_pos;
      prev_level      <= filt_level;
    end else begin
      prev_level      <= held_level;
    end
  end

  // trigger decode: window entry or selected edge of the output
  reg trigger;
  always @* begin
    trigger = 1'b0;
    if (run_state == ST_RUN) begin
      if (window_on) begin
        trigger = filt_match & ~(prev_level ^ invert_bit);
      end else begin
        case (trig_mode)
          `WCC_EDGE_BOTH: trigger = filt_level ^ prev_level;
          `WCC_EDGE_FALL: trigger = ~filt_level & prev_level;
          `WCC_EDGE_RISE: trigger = filt_level & ~prev_level;
          default:        trigger = 1'b0;
        endcase
      end
    end
  end

  // wishbone: one wait state; read data taken with the request, write at the edge that ends the ack cycle
  wire       bus_req  = cyc_i & stb_i;
  wire       bus_take = bus_req & ~ack_o;
  wire [2:0] reg_idx  = adr_i[`WCC_ADR_IDX];
  wire       wr_hit   = bus_req & ack_o & we_i & sel_i[0];
  wire [7:0] wr_byte  = dat_i[7:0];
  wire       flag_clr = wr_hit & (reg_idx == `WCC_IDX_STATUS) &
                        wr_byte[`WCC_STA_FLAG];

  // one write strobe per register; unmapped indices match none of them
  wire       wr_control = wr_hit & (reg_idx == `WCC_IDX_CONTROL);
  wire       wr_pair    = wr_hit & (reg_idx == `WCC_IDX_PAIR);
  wire       wr_insel   = wr_hit & (reg_idx == `WCC_IDX_INSEL);
  wire       wr_reflvl  = wr_hit & (reg_idx == `WCC_IDX_REFLEVEL);
  wire       wr_irqctl  = wr_hit & (reg_idx == `WCC_IDX_IRQCTL);

  // flag: set wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      comparator_irq_flag <= 1'b0;
    end else if (trigger) begin
      comparator_irq_flag <= 1'b1;
    end else if (flag_clr) begin
      comparator_irq_flag <= 1'b0;
    end
  end

  assign irq_o = comparator_irq_flag & irq_enable;

  // control: reserved bit stays zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      control <= `WCC_RST_CONTROL;
    end else if (wr_control) begin
      control <= wr_byte & `WCC_MSK_CONTROL;
    end
  end

  // pair select: upper bits reserved
  always @(posedge clk_i) begin
    if (rst_i) begin
      pair_control <= `WCC_RST_PAIR;
    end else if (wr_pair) begin
      pair_control <= wr_byte & `WCC_MSK_PAIR;
    end
  end

  // input select: every bit writable
  always @(posedge clk_i) begin
    if (rst_i) begin
      input_select_control <= `WCC_RST_INSEL;
    end else if (wr_insel) begin
      input_select_control <= wr_byte;
    end
  end

  // reference level: every bit writable
  always @(posedge clk_i) begin
    if (rst_i) begin
      reference_level <= `WCC_RST_REFLEVEL;
    end else if (wr_reflvl) begin
      reference_level <= wr_byte;
    end
  end

  // interrupt control: mode and enable only
  always @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_control <= `WCC_RST_IRQCTL;
    end else if (wr_irqctl) begin
      interrupt_control <= wr_byte & `WCC_MSK_IRQCTL;
    end
  end

  // status byte; bits without a function read zero
  reg [7:0] status_byte;
  always @* begin
    status_byte                  = 8'h00;
    status_byte[`WCC_STA_WINPOS] = window_position;
    status_byte[`WCC_STA_STATE]  = state_bit;
    status_byte[`WCC_STA_FLAG]   = comparator_irq_flag;
  end

  // read mux; unmapped indices read zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (reg_idx)
      `WCC_IDX_CONTROL:  rd_byte = control;
      `WCC_IDX_PAIR:     rd_byte = pair_control;
      `WCC_IDX_INSEL:    rd_byte = input_select_control;
      `WCC_IDX_REFLEVEL: rd_byte = reference_level;
      `WCC_IDX_IRQCTL:   rd_byte = interrupt_control;
      `WCC_IDX_STATUS:   rd_byte = status_byte;
      default:           rd_byte = 8'h00;
    endcase
  end

  // ack drops the cycle after it is given, so a held request is answered
  // only every other cycle; masters must release between transfers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_take;
    end
  end

  // read data captured when the request is taken and held until the next
  // one, so it stands through the ack cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_take) begin
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule // wcc_core
`default_nettype wire

// ### tb/wcc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module wcc_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  adr_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleep_idle_i,
  input wire logic        sleep_standby_i,
  input wire logic        sleep_powerdown_i,
  input wire logic        analog_enable_o,
  input wire logic        pin_out_o,
  input wire logic        pin_oe_n_o,
  input wire logic        event_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers exactly one cycle after a fresh request, for one cycle only
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_unmapped_reads_zero: assert property (ack_o && !we_i &&
    (adr_i[4:2] == 3'h3 || adr_i[4:2] == 3'h4) |-> dat_o == 32'h0)
    else $error("unmapped index read nonzero");
  // a pending request may only drop through a register write
  a_irq_held: assert property (irq_o && !(cyc_i && stb_i && we_i && ack_o) |=> irq_o)
    else $error("irq dropped without a write");
  a_powerdown_off: assert property (sleep_powerdown_i |-> pin_oe_n_o && !analog_enable_o)
    else $error("power down left comparator or pin driver on");
  a_event_is_pin: assert property (event_o == pin_out_o)
    else $error("event level differs from pin level");
  a_idle_no_effect: assert property ($changed(sleep_idle_i) && $stable(sleep_standby_i) &&
    $stable(sleep_powerdown_i) && !$past(ack_o) |-> $stable(analog_enable_o))
    else $error("idle sleep changed the comparator enable");
  // the first edge after a stop still swaps the live level for the held one
  a_disabled_holds: assert property (!analog_enable_o && !$past(analog_enable_o) &&
    !$past(analog_enable_o, 2) && !$past(ack_o) |-> $stable(event_o))
    else $error("event moved while comparator halted");
endmodule // wcc_monitor

bind wcc_core wcc_monitor u_wcc_monitor (.clk_i, .rst_i, .adr_i, .cyc_i, .stb_i, .we_i,
  .dat_o, .ack_o, .sleep_idle_i, .sleep_standby_i, .sleep_powerdown_i, .analog_enable_o,
  .pin_out_o, .pin_oe_n_o, .event_o, .irq_o);
`default_nettype wire

// ### tb/wcc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module wcc_analog_model #(
  parameter int VREF_MV = 2048
) (
  input  wire logic       clk_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] pos_sel_i,
  input  wire logic [2:0] neg_sel_i,
  input  wire logic [7:0] ref_level_i,
  output logic            raw_o,
  output logic            pair_raw_o
);
  int   pos_mv [4] = '{500, 500, 500, 500};
  int   neg_mv [4] = '{0, 0, 0, 0};
  int   lower_mv   = 0;
  int   settle     = 0;
  int   vpos;
  int   vneg;
  logic junk       = 1'b0;
  logic ready;
  // settling count; garbage only while an enabled core settles, a
  // disabled core keeps comparing so a missing run gate would show
  always @(posedge clk_i) begin
    settle <= enable_i ? ((settle < 120) ? settle + 1 : settle) : 0;
    junk   <= ~junk;
  end
  // pair shares the positive pin, lower limit on its negative side
  always_comb begin
    ready      = enable_i && settle >= 90;
    vpos       = pos_mv[pos_sel_i[1:0]];
    vneg       = (neg_sel_i == 3'h3) ? ref_level_i * VREF_MV / 256 : neg_mv[neg_sel_i[1:0]];
    raw_o      = (ready || !enable_i) ? (vpos > vneg) : junk;
    pair_raw_o = (ready || !enable_i) ? (vpos > lower_mv) : ~junk;
  end
endmodule // wcc_analog_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  adr_i = 5'h00;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        sleep_idle_i = 1'b0;
  logic        sleep_standby_i = 1'b0;
  logic        sleep_powerdown_i = 1'b0;
  logic        pair_next2_raw_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, cmp_raw_i, pair_next1_raw_i, analog_enable_o;
  logic        pin_out_o, pin_oe_n_o, event_o, irq_o;
  logic [1:0]  hysteresis_select_o, power_profile_o;
  logic [2:0]  positive_input_select_o, negative_input_select_o;
  logic [7:0]  reference_level_o, rd;
  int          miscompares = 0;
  int          samples_checked = 0;

  wcc_core u_wcc_core (.clk_i, .rst_i, .adr_i, .cyc_i, .stb_i, .we_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .cmp_raw_i, .pair_next1_raw_i, .pair_next2_raw_i,
    .sleep_idle_i, .sleep_standby_i, .sleep_powerdown_i, .analog_enable_o,
    .hysteresis_select_o, .power_profile_o, .positive_input_select_o,
    .negative_input_select_o, .reference_level_o, .pin_out_o, .pin_oe_n_o, .event_o, .irq_o);
  wcc_analog_model u_model (.clk_i, .enable_i(analog_enable_o),
    .pos_sel_i(positive_input_select_o), .neg_sel_i(negative_input_select_o),
    .ref_level_i(reference_level_o), .raw_o(cmp_raw_i), .pair_raw_o(pair_next1_raw_i));

  // free running 100 MHz clock
  initial forever #5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; entered just after a rising edge, waits for ack
  task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_regs;
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    logic [7:0] mk [7] = '{8'hdf, 8'h03, 8'hff, 8'h00, 8'h00, 8'hff, 8'h31};
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, i[2:0], 8'h00);
      check(rd, rv[i]);
    end
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, i[2:0], 8'hff);
      wb(1'b0, i[2:0], 8'h00);
      check(rd, mk[i]);
    end
    check({hysteresis_select_o, power_profile_o}, 4'hf);
    check({positive_input_select_o, negative_input_select_o}, 6'h3f);
    for (int i = 0; i < 7; i++) wb(1'b1, i[2:0], 8'h00);
  endtask

  task automatic t_start;
    wb(1'b1, 3'h5, 8'h80);
    wb(1'b1, 3'h2, 8'h43);
    wb(1'b1, 3'h0, 8'h41);
    wait_cyc(40);
    check(pin_out_o, 1'b1);
    wait_cyc(80);
    check({pin_out_o, pin_oe_n_o}, 2'b00);
    u_model.pos_mv[0] <= 1500;
    wait_cyc(10);
    check({pin_out_o, event_o}, 2'b11);
    wb(1'b1, 3'h2, 8'hc3);
    wait_cyc(10);
    check(pin_out_o, 1'b0);
    wb(1'b1, 3'h2, 8'h03);
    // full scale reference sits at 2040 mV; equal inputs must read low
    wb(1'b1, 3'h5, 8'hff);
    u_model.pos_mv[0] <= 2041;
    wait_cyc(10);
    check(pin_out_o, 1'b1);
    u_model.pos_mv[0] <= 2040;
    wait_cyc(10);
    check(pin_out_o, 1'b0);
    wb(1'b1, 3'h5, 8'h80);
    u_model.pos_mv[0] <= 500;
    wait_cyc(10);
  endtask

  task automatic t_edges;
    for (int m = 0; m < 5; m++) begin
      // last pass repeats both edges with the request gate closed
      wb(1'b1, 3'h6, {2'h0, m[1:0], 3'h0, m < 4});
      wb(1'b1, 3'h7, 8'h01);
      u_model.pos_mv[0] <= 1500;
      wait_cyc(10);
      wb(1'b1, 3'h7, 8'h00);
      wb(1'b0, 3'h7, 8'h00);
      check(rd[0], m[1:0] == 2'h0 || m == 3);
      check(irq_o, m == 0 || m == 3);
      wb(1'b1, 3'h7, 8'h01);
      u_model.pos_mv[0] <= 500;
      wait_cyc(10);
      wb(1'b0, 3'h7, 8'h00);
      check(rd[0], m[1:0] == 2'h0 || m == 2);
    end
  endtask

  task automatic t_window;
    int v [3] = '{1500, 800, 200};
    u_model.lower_mv <= 500;
    wb(1'b1, 3'h1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_model.pos_mv[0] <= v[i];
      for (int m = 0; m < 4; m++) begin
        wb(1'b1, 3'h6, {2'h0, m[1:0], 4'h1});
        wait_cyc(10);
        wb(1'b0, 3'h7, 8'h00);
        check(rd[7:6], i[1:0]);
        check(rd[4], i == m || (m == 3 && i != 1));
      end
    end
    // second partner stays low, so inside via the first reads below here
    u_model.pos_mv[0] <= 800;
    wb(1'b1, 3'h1, 8'h02);
    wait_cyc(10);
    wb(1'b0, 3'h7, 8'h00);
    check(rd[7:6], 2'h2);
    check(rd[4], 1'b1);
    wb(1'b1, 3'h1, 8'h00);
  endtask

  task automatic t_sleep;
    sleep_idle_i <= 1'b1;
    wait_cyc(3);
    check(analog_enable_o, 1'b1);
    sleep_idle_i    <= 1'b0;
    sleep_standby_i <= 1'b1;
    wait_cyc(3);
    check(analog_enable_o, 1'b0);
    wb(1'b1, 3'h0, 8'hc1);
    check(analog_enable_o, 1'b1);
    sleep_standby_i   <= 1'b0;
    sleep_powerdown_i <= 1'b1;
    wait_cyc(3);
    check({analog_enable_o, pin_oe_n_o}, 2'b01);
    sleep_powerdown_i <= 1'b0;
    // halted comparator must not raise the flag on an input swing
    wb(1'b1, 3'h0, 8'h40);
    wb(1'b1, 3'h7, 8'h01);
    u_model.pos_mv[0] <= 1500;
    wait_cyc(10);
    wb(1'b0, 3'h7, 8'h00);
    check(rd[0], 1'b0);
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence after 16 cycles of reset
  initial begin
    wait_cyc(16);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_start();
    t_edges();
    t_window();
    t_sleep();
    print_verdict();
  end

  // hang guard, about eight times the expected run
  initial begin
    wait_cyc(6000);
    miscompares++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
